/* design/hotplug_slot_power_control_por.v */
/*
  Control front end of a dual-slot hot-plug power controller: power-on
  reset sequencing from the standby supply, pin-level and serial
  management control paths, fault status and interrupt, gate drive state.
  Assumes every pin input is asynchronous to ref_clk; SCL is far slower
  than ref_clk and is sampled, not used as a clock. Open-drain pins are
  resolved outside from the active-low enable.
*/
`timescale 1ns/1ps

`include "hotplug_defines.vh"

// Operation
// - Power-on reset starts once the standby supply is valid and lasts until it held 250 us.
// - The slot, serial and interrupt registers are held cleared until the power-on reset ends.
// - Losing and regaining the standby supply starts a fresh power-on reset.
// - The management port answers only after the power-on reset has ended.
// - Every slot output stays off during the power-on reset.
// - Two control paths exist: slot enable and fault pins, and a serial port with interrupt.
// - Power is controlled by the pins and the serial port together; either path can turn a slot on.
// - With clock and data tied low at reset release, the serial port stays inactive.
// - The serial port reports each supply's fault and the general input pins.
// - With a slot's main supplies off, its high gate is pulled up and low gate pulled down.
// - An enabled slot switches its high gate to a current sink and low gate to a source.
// - The interrupt clears when the host writes a one into the fault bit or a zero into the slot's interrupt enable bit.
module hotplug_slot_power_control_por #(
  parameter POR_CYCLES = `POR_CYCLES
) (
  input wire ref_clk,
  input wire reset,
  input wire standbyValid,
  input wire [1:0] mainEnablePin,
  input wire [1:0] auxEnablePin,
  input wire [5:0] railFault,
  input wire [1:0] generalInputPins,
  input wire [2:0] busAddressStraps,
  input wire scl,
  input wire sdaIn,
  output reg sdaOut,
  output reg sdaOutEnableN,
  output wire [1:0] highRailGateSink,
  output wire [1:0] lowRailGateSource,
  output wire [1:0] auxRailOn,
  output reg [1:0] faultN,
  output reg intN,
  output reg porActive
);

  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_CMD = 3'h2;
  localparam ST_WDATA = 3'h3;
  localparam ST_RDATA = 3'h4;

  localparam SYNC_W = 18;

  wire [SYNC_W-1:0] asyncIn;
  reg [SYNC_W-1:0] syncMeta_reg;
  reg [SYNC_W-1:0] syncOut_reg;
  wire standbySync;
  wire [1:0] mainPinSync;
  wire [1:0] auxPinSync;
  wire [5:0] faultSync;
  wire [1:0] gpiSync;
  wire [2:0] strapSync;
  wire sclSync;
  wire sdaSync;

  reg [12:0] porCount_reg;
  reg smbDisabled_reg;
  reg sclPrev_reg;
  reg sdaPrev_reg;
  reg [2:0] state_reg;
  reg [3:0] bitCnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] pointer_reg;
  reg [7:0] tx_reg;
  reg [`CTRL_WIDTH-1:0] ctrl_reg [0:1];
  reg [`STAT_WIDTH-1:0] stat_reg [0:1];
  wire [1:0] mainTripped;
  wire clear;
  wire smbReady;
  wire sclRise;
  wire sclFall;
  wire startCond;
  wire stopCond;
  wire [6:0] ownAddress;
  wire [7:0] readData;

  assign asyncIn = {standbyValid, mainEnablePin, auxEnablePin, railFault,
                    generalInputPins, busAddressStraps, scl, sdaIn};
  assign {standbySync, mainPinSync, auxPinSync, faultSync,
          gpiSync, strapSync, sclSync, sdaSync} = syncOut_reg;

  // Pins change with no regard to ref_clk, so nothing reads them before two flops.
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      syncMeta_reg <= {SYNC_W{1'b0}};
      syncOut_reg <= {SYNC_W{1'b0}};
    end
    else
    begin
      syncMeta_reg <= asyncIn;
      syncOut_reg <= syncMeta_reg;
    end
  end

  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      porActive <= 1'b1;
      porCount_reg <= 13'h0000;
      smbDisabled_reg <= 1'b1;
    end
    else if (!standbySync)
    begin
      porActive <= 1'b1;
      porCount_reg <= 13'h0000;
    end
    else if (porActive)
    begin
      if (porCount_reg == POR_CYCLES[12:0] - 13'h0001)
      begin
        porActive <= 1'b0;
        smbDisabled_reg <= !sclSync && !sdaSync;
      end
      else
        porCount_reg <= porCount_reg + 13'h0001;
    end
  end

  // The synced supply drop clears at once, so no output stays on in the first reset cycle.
  assign clear = reset | porActive | !standbySync;
  assign smbReady = !porActive && !smbDisabled_reg;
  assign ownAddress = {`SMB_ADDR_BASE, strapSync};
  assign sclRise = sclSync && !sclPrev_reg;
  assign sclFall = !sclSync && sclPrev_reg;
  assign startCond = sclSync && sclPrev_reg && sdaPrev_reg && !sdaSync;
  assign stopCond = sclSync && sclPrev_reg && !sdaPrev_reg && sdaSync;

  function [7:0] readMux;
    input [7:0] cmd;
    begin
      case (cmd)
        `CMD_SLOT_CTRL_A: readMux = {5'h00, ctrl_reg[0]};
        `CMD_SLOT_CTRL_B: readMux = {5'h00, ctrl_reg[1]};
        `CMD_SLOT_STAT_A: readMux = {5'h00, stat_reg[0]};
        `CMD_SLOT_STAT_B: readMux = {5'h00, stat_reg[1]};
        `CMD_COMMON_STAT: readMux = {2'h0, gpiSync, 4'h0};
        default: readMux = 8'h00;
      endcase
    end
  endfunction

  assign readData = readMux(pointer_reg);

  // Serial management slave: 7-bit address, command byte, one data byte.
  always @(posedge ref_clk)
  begin
    if (clear)
    begin
      // Edge history tracks the pins in reset, so a transfer under way cannot look like a start.
      sclPrev_reg <= sclSync;
      sdaPrev_reg <= sdaSync;
      state_reg <= ST_IDLE;
      bitCnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      pointer_reg <= 8'h00;
      tx_reg <= 8'h00;
      sdaOut <= 1'b0;
      sdaOutEnableN <= 1'b1;
    end
    else
    begin
      sclPrev_reg <= sclSync;
      sdaPrev_reg <= sdaSync;
      if (!smbReady || stopCond)
      begin
        state_reg <= ST_IDLE;
        sdaOutEnableN <= 1'b1;
      end
      else if (startCond)
      begin
        state_reg <= ST_ADDR;
        bitCnt_reg <= 4'h0;
        sdaOutEnableN <= 1'b1;
      end
      else if (state_reg != ST_IDLE)
      begin
        if (sclRise)
        begin
          shift_reg <= {shift_reg[6:0], sdaSync};
          bitCnt_reg <= bitCnt_reg + 4'h1;
        end
        else if (sclFall)
        begin
          if (bitCnt_reg == 4'h8)
          begin
            sdaOutEnableN <= 1'b1;
            case (state_reg)
              ST_ADDR:
              begin
                if (shift_reg[7:1] == ownAddress)
                begin
                  sdaOutEnableN <= 1'b0;
                  state_reg <= shift_reg[0] ? ST_RDATA : ST_CMD;
                end
                else
                  state_reg <= ST_IDLE;
              end
              ST_CMD:
              begin
                pointer_reg <= shift_reg;
                sdaOutEnableN <= 1'b0;
                state_reg <= ST_WDATA;
              end
              ST_WDATA:
                sdaOutEnableN <= 1'b0;
              default:
                sdaOutEnableN <= 1'b1;
            endcase
          end
          else if (bitCnt_reg == 4'h9)
          begin
            bitCnt_reg <= 4'h0;
            if (state_reg == ST_RDATA && !shift_reg[0])
            begin
              tx_reg <= readData;
              sdaOutEnableN <= readData[7];
            end
            else
            begin
              sdaOutEnableN <= 1'b1;
              if (state_reg == ST_RDATA)
                state_reg <= ST_IDLE;
            end
          end
          else if (state_reg == ST_RDATA)
            sdaOutEnableN <= tx_reg[3'h7 - bitCnt_reg[2:0]];
        end
      end
    end
  end

  // Fault bits are sticky; a new fault in the write-one-to-clear cycle survives.
  genvar s;
  generate
    for (s = 0; s < 2; s = s + 1)
    begin : slot
      wire writeHit;
      assign writeHit = smbReady && sclFall && bitCnt_reg == 4'h8
                        && state_reg == ST_WDATA;

      always @(posedge ref_clk)
      begin
        if (clear)
        begin
          ctrl_reg[s] <= `CTRL_RESET;
          stat_reg[s] <= `STAT_RESET;
          faultN[s] <= 1'b1;
        end
        else
        begin
          // The pin path drives power on its own; serial writes only add to it.
          if (writeHit && pointer_reg == `CMD_SLOT_CTRL_A + s)
            ctrl_reg[s] <= shift_reg[`CTRL_WIDTH-1:0];
          if (writeHit && pointer_reg == `CMD_SLOT_STAT_A + s)
            stat_reg[s] <= (stat_reg[s] & ~shift_reg[`STAT_WIDTH-1:0])
                           | faultSync[3*s +: 3];
          else
            stat_reg[s] <= stat_reg[s] | faultSync[3*s +: 3];
          faultN[s] <= !(mainTripped[s] && mainPinSync[s]);
        end
      end

      slot_gate_drive u_gate (
        .ref_clk(ref_clk),
        .clear(clear),
        .mainEnable(mainPinSync[s] | ctrl_reg[s][`CTRL_MAIN_BIT]),
        .auxEnable(auxPinSync[s] | ctrl_reg[s][`CTRL_AUX_BIT]),
        .railFault(faultSync[3*s +: 3]),
        .highRailGateSink(highRailGateSink[s]),
        .lowRailGateSource(lowRailGateSource[s]),
        .auxRailOn(auxRailOn[s]),
        .mainTripped(mainTripped[s])
      );
    end
  endgenerate

  always @(posedge ref_clk)
  begin
    if (clear)
      intN <= 1'b1;
    else
      intN <= !(|(stat_reg[0] & {`STAT_WIDTH{ctrl_reg[0][`CTRL_INT_EN_BIT]}})
                | |(stat_reg[1] & {`STAT_WIDTH{ctrl_reg[1][`CTRL_INT_EN_BIT]}}));
  end

endmodule

/* include/hotplug_defines.vh */
/*
  Shared constants of the dual-slot hot-plug power control front end:
  power-on reset timing, management port addressing, command codes and
  register field positions.
  Assumes a 25 MHz reference clock and inclusion by bare name.
*/
`ifndef HOTPLUG_DEFINES_VH
`define HOTPLUG_DEFINES_VH

`define CLK_FREQ_MHZ 25
`define POR_TIME_US 250
`define POR_CYCLES (`POR_TIME_US * `CLK_FREQ_MHZ)

`define SMB_ADDR_BASE 4'h8

`define CMD_SLOT_CTRL_A 8'h00
`define CMD_SLOT_CTRL_B 8'h01
`define CMD_SLOT_STAT_A 8'h02
`define CMD_SLOT_STAT_B 8'h03
`define CMD_COMMON_STAT 8'h04

`define CTRL_MAIN_BIT 0
`define CTRL_AUX_BIT 1
`define CTRL_INT_EN_BIT 2
`define CTRL_WIDTH 3
`define CTRL_RESET 3'h0

`define STAT_FAULT_12V_BIT 0
`define STAT_FAULT_3V_BIT 1
`define STAT_FAULT_AUX_BIT 2
`define STAT_WIDTH 3
`define STAT_RESET 3'h0

`define COMMON_GPI_A_BIT 4
`define COMMON_GPI_B_BIT 5

`endif

/* design/slot_gate_drive.v */
/*
  Gate drive state of one slot: main rail gates, auxiliary rail switch and
  the main and auxiliary circuit breaker trip latches.
  Assumes synchronised enables and fault levels on the ref_clk domain, and
  a clear input held high through reset and the power-on reset interval.
*/
`timescale 1ns/1ps

module slot_gate_drive (
  input wire ref_clk,
  input wire clear,
  input wire mainEnable,
  input wire auxEnable,
  input wire [2:0] railFault,
  output reg highRailGateSink,
  output reg lowRailGateSource,
  output reg auxRailOn,
  output reg mainTripped
);

  wire mainFault;
  reg auxTripped_reg;

  assign mainFault = railFault[0] | railFault[1];

  always @(posedge ref_clk)
  begin
    if (clear)
    begin
      highRailGateSink <= 1'b0;
      lowRailGateSource <= 1'b0;
      auxRailOn <= 1'b0;
      mainTripped <= 1'b0;
      auxTripped_reg <= 1'b0;
    end
    else
    begin
      // A trip holds until its enable is dropped, so a fault cannot chatter.
      if (!mainEnable)
        mainTripped <= 1'b0;
      else if (mainFault && highRailGateSink)
        mainTripped <= 1'b1;
      if (!auxEnable)
        auxTripped_reg <= 1'b0;
      else if (railFault[2] && auxRailOn)
        auxTripped_reg <= 1'b1;
      highRailGateSink <= mainEnable && !mainTripped && !mainFault;
      lowRailGateSource <= mainEnable && !mainTripped && !mainFault;
      auxRailOn <= auxEnable && !auxTripped_reg && !railFault[2];
    end
  end

endmodule

/* verif/hotplug_por_props.sv */
/*
  Assertion checker for the hot-plug power control front end.
  Assumes a bind to the top module and its port names.
*/
`timescale 1ns/1ps
module hotplug_por_props #(
  parameter POR_CYCLES = 20
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic standbyValid,
  input wire logic [1:0] mainEnablePin,
  input wire logic [5:0] railFault,
  input wire logic sdaOutEnableN,
  input wire logic [1:0] highRailGateSink,
  input wire logic [1:0] lowRailGateSource,
  input wire logic [1:0] auxRailOn,
  input wire logic [1:0] faultN,
  input wire logic intN,
  input wire logic porActive
);
  // Counts valid supply cycles; one less than the count allows for a pre-synced supply.
  logic [15:0] upCnt;
  always_ff @(posedge ref_clk)
  begin
    if (reset || !standbyValid)
      upCnt <= 16'h0000;
    else if (upCnt != 16'hFFFF)
      upCnt <= upCnt + 16'h0001;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_porOut;
    porActive |-> highRailGateSink == 2'h0 && lowRailGateSource == 2'h0 && auxRailOn == 2'h0;
  endproperty
  a_porOut: assert property (p_porOut) else $error("output on in reset");
  property p_porLen;
    $fell(porActive) |-> upCnt >= POR_CYCLES - 1;
  endproperty
  a_porLen: assert property (p_porLen) else $error("reset interval short");
  property p_restart;
    !standbyValid |-> ##[1:4] porActive;
  endproperty
  a_restart: assert property (p_restart) else $error("no new reset");
  property p_porSda;
    porActive |-> sdaOutEnableN;
  endproperty
  a_porSda: assert property (p_porSda) else $error("serial answer in reset");
  property p_porFlags;
    porActive |-> intN && faultN == 2'h3;
  endproperty
  a_porFlags: assert property (p_porFlags) else $error("flags not cleared");
  property p_gatePair;
    highRailGateSink == lowRailGateSource;
  endproperty
  a_gatePair: assert property (p_gatePair) else $error("gates disagree");
  property p_gateOn;
    (mainEnablePin[0] && faultN[0] && railFault[2:0] == 3'h0 && !porActive) [*6]
      |-> highRailGateSink[0];
  endproperty
  a_gateOn: assert property (p_gateOn) else $error("gate not driven");
  property p_trip;
    highRailGateSink[0] && railFault[0] |-> ##[1:5] !highRailGateSink[0];
  endproperty
  a_trip: assert property (p_trip) else $error("gate not released");
endmodule
bind hotplug_slot_power_control_por hotplug_por_props #(.POR_CYCLES(POR_CYCLES)) u_props (
  .ref_clk, .reset, .standbyValid, .mainEnablePin, .railFault, .sdaOutEnableN,
  .highRailGateSink, .lowRailGateSource, .auxRailOn, .faultN, .intN, .porActive);

/* verif/smbus_host_model.sv */
/*
  Host controller model on the serial management port.
  Assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/1ps
module smbus_host_model (
  input wire logic ref_clk,
  input wire logic sdaIn,
  output logic scl,
  output logic sdaRel
);
  logic r;
  initial
  begin
    scl = 1'b1;
    sdaRel = 1'b1;
  end
  // A quarter of the 320 ns bit; moves land on falling edges only.
  task automatic q;
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic bitx(input logic b, output logic s);
    sdaRel = b;
    q();
    scl = 1'b1;
    q();
    s = sdaIn;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic start;
    sdaRel = 1'b1;
    q();
    scl = 1'b1;
    q();
    sdaRel = 1'b0;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic stop;
    sdaRel = 1'b0;
    q();
    scl = 1'b1;
    q();
    sdaRel = 1'b1;
    q();
  endtask
  task automatic sendByte(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--)
      bitx(v[i], r);
    bitx(1'b1, ack);
  endtask
  task automatic readByte(output logic [7:0] v);
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, v[i]);
    bitx(1'b1, r);
  endtask
  task automatic tie(input logic v);
    scl = v;
    sdaRel = v;
  endtask
endmodule

/* verif/hotplug_slot_power_control_por_tb.sv */
/*
  Self-checking bench for the hot-plug power control front end.
  Assumes the checker is bound to the design and POR_CYCLES is 20.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module hotplug_slot_power_control_por_tb;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic standbyValid = 1'b0;
  logic [1:0] mainEnablePin = 2'h0;
  logic [1:0] auxEnablePin = 2'h0;
  logic [5:0] railFault = 6'h00;
  logic [1:0] generalInputPins = 2'h2;
  logic scl, sdaRel, sdaOut, sdaOutEnableN, intN, porActive;
  logic [1:0] highRailGateSink, lowRailGateSource, auxRailOn, faultN;
  wire logic sdaIn = sdaRel & (sdaOutEnableN | sdaOut);
  int fail_count = 0;
  int n_tests = 0;
  int n;
  logic [2:0] k;
  logic [7:0] d;
  // Rows: enables, aux enables, rail faults, then gate, source, aux and fault outputs.
  logic [17:0] rows [6] = '{18'h00003, 18'h10053, 18'h380FB, 18'h381AA, 18'h280AB, 18'h04007};
  initial forever #20 ref_clk = ~ref_clk;
  hotplug_slot_power_control_por #(.POR_CYCLES(20)) u_dut (
    .ref_clk, .reset, .standbyValid, .mainEnablePin, .auxEnablePin, .railFault,
    .generalInputPins, .busAddressStraps(3'h5), .scl, .sdaIn, .sdaOut, .sdaOutEnableN,
    .highRailGateSink, .lowRailGateSource, .auxRailOn, .faultN, .intN, .porActive);
  smbus_host_model u_host (.ref_clk, .sdaIn, .scl, .sdaRel);
  task automatic give_verdict;
    $display("checks %0d failures %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge ref_clk);
  endtask
  task automatic waitPor;
    n = 0;
    while (porActive !== 1'b0 && n < 200)
    begin
      cyc(1);
      n++;
    end
    if (n >= 200)
    begin
      fail_count++;
      give_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] v);
    u_host.start();
    u_host.sendByte(8'h8A, k[2]);
    u_host.sendByte(c, k[1]);
    u_host.sendByte(v, k[0]);
    u_host.stop();
  endtask
  task automatic rd(input logic [7:0] c);
    u_host.start();
    u_host.sendByte(8'h8A, k[2]);
    u_host.sendByte(c, k[1]);
    u_host.start();
    u_host.sendByte(8'h8B, k[0]);
    u_host.readByte(d);
    u_host.stop();
  endtask
  initial
  begin
    #1ms;
    fail_count++;
    give_verdict();
  end
  initial
  begin
    cyc(5);
    reset = 1'b0;
    mainEnablePin = 2'h3;
    cyc(3);
    `CHK(porActive, 1'b1)
    standbyValid = 1'b1;
    cyc(10);
    standbyValid = 1'b0;
    cyc(2);
    standbyValid = 1'b1;
    waitPor();
    `CHK(n >= 20 && n <= 24, 1'b1)
    cyc(6);
    `CHK(highRailGateSink, 2'h3)
    foreach (rows[i])
    begin
      {mainEnablePin, auxEnablePin, railFault} = rows[i][17:8];
      cyc(6);
      `CHK({highRailGateSink, lowRailGateSource, auxRailOn, faultN}, rows[i][7:0])
    end
    // Serial control from here on, so the enable pins stay off.
    auxEnablePin = 2'h0;
    wr(8'h00, 8'h01);
    cyc(6);
    `CHK({k, highRailGateSink}, 5'h01)
    rd(8'h02);
    `CHK(d, 8'h01)
    rd(8'h04);
    `CHK(d & 8'h30, 8'h20)
    wr(8'h00, 8'h04);
    cyc(4);
    `CHK(intN, 1'b0)
    wr(8'h02, 8'h00);
    cyc(4);
    `CHK(intN, 1'b0)
    wr(8'h02, 8'h01);
    cyc(4);
    `CHK(intN, 1'b1)
    standbyValid = 1'b0;
    cyc(4);
    `CHK(porActive, 1'b1)
    standbyValid = 1'b1;
    wr(8'h00, 8'h01);
    `CHK(k, 3'h7)
    rd(8'h00);
    `CHK(d, 8'h00)
    standbyValid = 1'b0;
    u_host.tie(1'b0);
    cyc(4);
    standbyValid = 1'b1;
    cyc(30);
    u_host.tie(1'b1);
    wr(8'h00, 8'h01);
    `CHK({k, highRailGateSink}, 5'h1C)
    give_verdict();
  end
endmodule
